//--- hw/scs_pkg.sv
// Shared constants and types of the system clock source selector.
package scs_pkg;

    // Width of the clock source select field.
    localparam int SEL_W = 2;

    // Select codes as software writes them into the source select field.
    localparam logic [SEL_W-1:0] SEL_WAKEUP   = 2'h0;
    localparam logic [SEL_W-1:0] SEL_RESERVED = 2'h1;
    localparam logic [SEL_W-1:0] SEL_PRESCALE = 2'h2;
    localparam logic [SEL_W-1:0] SEL_DIRECT   = 2'h3;

    // Level of the VCO bypass bit that routes the oscillator through the prescaler.
    localparam logic VCO_BYPASS_ON = 1'h1;

    // Prescaler divider field width and the largest factor it must reach.
    localparam int PRESCALE_DIV_W      = 10;
    localparam int PRESCALE_MAX_FACTOR = 1024;

    // Divider value used after reset, which is a factor of one.
    localparam logic [PRESCALE_DIV_W-1:0] PRESCALE_DIV_RST = 10'h000;

    // Clock path that actually drives the system clock.
    typedef enum logic [1:0] {
        PATH_WAKEUP   = 2'b00,
        PATH_PLL      = 2'b01,
        PATH_PRESCALE = 2'b10,
        PATH_DIRECT   = 2'b11
    } scs_path_e;

    // Path in use after reset.
    localparam scs_path_e PATH_RST = PATH_WAKEUP;

    // States of the glitch-free switch sequence.
    typedef enum logic [1:0] {
        SW_RUN   = 2'b00,
        SW_DRAIN = 2'b01,
        SW_ARM   = 2'b10
    } scs_switch_e;

    // Reset value of the switch sequence.
    localparam scs_switch_e SW_RST = SW_RUN;

endpackage

//--- hw/scs_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Output prescaler: divides the sampled oscillator level by divider field plus one.
module scs_prescaler #(
    parameter int DIV_W = scs_pkg::PRESCALE_DIV_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             oscLevel,
    input  wire logic [DIV_W-1:0] divField,
    output logic                  divClk
);

    // The divider must be wide enough for the largest documented factor.
    if ((64'h1 << DIV_W) < 64'(scs_pkg::PRESCALE_MAX_FACTOR)) begin : g_width_check
        $error("scs_prescaler: DIV_W too small for the largest factor");
    end

    logic             oscPrev_r;   // Oscillator level one cycle ago.
    logic [DIV_W-1:0] cnt_r;       // Oscillator periods counted in the current output period.
    logic [DIV_W-1:0] factorM1_r;  // Divider in force, changed only at a period boundary.
    logic             divClk_r;    // Divided clock level.
    logic             oscRise;     // Rising edge of the oscillator.
    logic             wrap;        // Last oscillator period of the output period.
    logic [DIV_W:0]   highLen;     // Oscillator periods spent high per output period.
    logic [DIV_W:0]   cntPlus;     // Count of the period that starts now.

    assign oscRise = oscLevel & ~oscPrev_r;
    assign wrap    = (cnt_r == factorM1_r);
    assign highLen = ({1'b0, factorM1_r} + (DIV_W+1)'(2)) >> 1;
    assign cntPlus = {1'b0, cnt_r} + (DIV_W+1)'(1);
    assign divClk  = divClk_r;

    // Edge detector on the oscillator level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscPrev_r <= 1'b0;
        end else begin
            oscPrev_r <= oscLevel;
        end
    end

    // Period counter that restarts after divider plus one oscillator periods.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (oscRise) begin
            cnt_r <= wrap ? '0 : cnt_r + DIV_W'(1); // RULE_03
        end
    end

    // A new divider is taken only at a boundary so no output pulse is cut short.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            factorM1_r <= DIV_W'(scs_pkg::PRESCALE_DIV_RST);
        end else if (oscRise && wrap) begin
            factorM1_r <= divField; // RULE_05
        end
    end

    // Output level: follows the oscillator at factor one, else high for the first half of the periods, rounded up.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divClk_r <= 1'b0;
        end else if (factorM1_r == '0) begin
            divClk_r <= oscLevel; // RULE_04
        end else if (oscRise) begin
            divClk_r <= wrap ? 1'b1 : (cntPlus < highLen); // RULE_03
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wrap_restart_a: assert property (oscRise && wrap |=> cnt_r == '0) // RULE_03
        else $error("prescaler count did not restart after the last period");
    bypass_follow_a: assert property (factorM1_r == '0 |=> divClk_r == $past(oscLevel)) // RULE_04
        else $error("factor one does not pass the oscillator through");
    count_range_a: assert property (cnt_r <= factorM1_r) // RULE_05
        else $error("prescaler count beyond the divider");
    period_start_a: assert property (oscRise && wrap |=> divClk_r) // RULE_03
        else $error("divided clock not high at period start");
    cover_divide: cover property (factorM1_r == DIV_W'(2) && oscRise && wrap);

endmodule // scs_prescaler
`default_nettype wire

//--- hw/scs_clock_select.sv
// Behaviour
// RULE_01: Select 11 drives clock from direct input.
// RULE_02: Select 10 with bypass uses output prescaler.
// RULE_03: Prescaler divides oscillator by divider plus one.
// RULE_04: Factor one passes oscillator through unchanged.
// RULE_05: Prescaler factors reach up to 1024.
// RULE_06: Select 10 without bypass uses PLL output.
// RULE_07: Select 00 runs from wakeup clock.
// RULE_08: Glitch-free switching; select 01 is reserved.
`timescale 1ns/1ps
`default_nettype none
// System clock source selector. All clock sources arrive as levels that are
// sampled on clk, so the system clock produced here is a registered level.
module scs_clock_select #(
    parameter int DIV_W = scs_pkg::PRESCALE_DIV_W
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     directClockInput,
    input  wire logic                     crystalInput,
    input  wire logic                     internalClockSource,
    input  wire logic                     useInternalOsc,
    input  wire logic                     pllClock,
    input  wire logic                     wakeupClock,
    input  wire logic [scs_pkg::SEL_W-1:0] clockSourceSelect,
    input  wire logic                     vcoBypass,
    input  wire logic [DIV_W-1:0]         prescalerDividerField,
    output logic                          systemClock,
    output logic [1:0]                    activePath,
    output logic                          switchBusy,
    output logic                          reservedSelect
);

    // The divider must at least cover the documented largest factor.
    if (DIV_W < scs_pkg::PRESCALE_DIV_W) begin : g_div_check
        $error("scs_clock_select: DIV_W below the documented divider width");
    end

    scs_pkg::scs_path_e   activePath_r;   // Path currently driving the system clock.
    scs_pkg::scs_path_e   targetPath_r;   // Path being switched to.
    scs_pkg::scs_path_e   reqPath;        // Path the select inputs ask for.
    scs_pkg::scs_switch_e swState_r;      // Switch sequence state.
    scs_pkg::scs_switch_e swState_nxt;    // Next switch sequence state.
    logic                 systemClock_r;  // Registered system clock level.
    logic                 reservedSel_r;  // Reserved select code seen.
    logic                 oscLevel;       // Oscillator feeding the prescaler.
    logic                 prescaleClk;    // Divided oscillator.
    logic                 activeLevel;    // Level of the active path.
    logic                 targetLevel;    // Level of the target path.

    // Function returning the level of one clock path.
    function automatic logic pathLevel(input scs_pkg::scs_path_e p,
                                       input logic wu, input logic pl,
                                       input logic ps, input logic dr);
        logic lvl;
        lvl = 1'b0;
        unique case (p)
            scs_pkg::PATH_WAKEUP:   lvl = wu;
            scs_pkg::PATH_PLL:      lvl = pl;
            scs_pkg::PATH_PRESCALE: lvl = ps;
            scs_pkg::PATH_DIRECT:   lvl = dr;
        endcase
        return lvl;
    endfunction

    // The prescaler runs from the crystal or from the internal source.
    assign oscLevel = useInternalOsc ? internalClockSource : crystalInput; // RULE_02

    // Output prescaler instance.
    scs_prescaler #(
        .DIV_W (DIV_W)
    ) u_prescaler (
        .clk      (clk),
        .rst_n    (rst_n),
        .oscLevel (oscLevel),
        .divField (prescalerDividerField),
        .divClk   (prescaleClk)
    );

    // Decode of the select inputs into a requested path.
    always_comb begin
        reqPath = activePath_r;
        unique case (clockSourceSelect)
            scs_pkg::SEL_WAKEUP: begin
                reqPath = scs_pkg::PATH_WAKEUP; // RULE_07
            end
            scs_pkg::SEL_RESERVED: begin
                // A reserved code leaves the current path in place.
                reqPath = activePath_r; // RULE_08
            end
            scs_pkg::SEL_PRESCALE: begin
                // The bypass bit chooses between prescaler and PLL.
                if (vcoBypass == scs_pkg::VCO_BYPASS_ON) begin
                    reqPath = scs_pkg::PATH_PRESCALE; // RULE_02
                end else begin
                    reqPath = scs_pkg::PATH_PLL; // RULE_06
                end
            end
            scs_pkg::SEL_DIRECT: begin
                reqPath = scs_pkg::PATH_DIRECT; // RULE_01
            end
        endcase
    end

    assign activeLevel = pathLevel(activePath_r, wakeupClock, pllClock, prescaleClk,
                                   directClockInput);
    assign targetLevel = pathLevel(targetPath_r, wakeupClock, pllClock, prescaleClk,
                                   directClockInput);

    // Switch sequence: drain the old clock to low, hold low, start on the new one.
    always_comb begin
        swState_nxt = swState_r;
        unique case (swState_r)
            scs_pkg::SW_RUN: begin
                // A change of request starts the drain phase.
                if (reqPath != activePath_r) begin
                    swState_nxt = scs_pkg::SW_DRAIN;
                end
            end
            scs_pkg::SW_DRAIN: begin
                // The old clock finishes its high phase before it is left.
                if (!activeLevel) begin
                    swState_nxt = scs_pkg::SW_ARM; // RULE_08
                end
            end
            scs_pkg::SW_ARM: begin
                // The new clock is joined only while it is low.
                if (!targetLevel) begin
                    swState_nxt = scs_pkg::SW_RUN; // RULE_08
                end
            end
            default: begin
                swState_nxt = scs_pkg::SW_RST;
            end
        endcase
    end

    // Switch state register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swState_r <= scs_pkg::SW_RST;
        end else begin
            swState_r <= swState_nxt;
        end
    end

    // Target path is captured when a switch starts.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            targetPath_r <= scs_pkg::PATH_RST;
        end else if (swState_r == scs_pkg::SW_RUN && reqPath != activePath_r) begin
            targetPath_r <= reqPath;
        end
    end

    // Active path changes only at the end of the hold-low phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activePath_r <= scs_pkg::PATH_RST;
        end else if (swState_r == scs_pkg::SW_ARM && !targetLevel) begin
            activePath_r <= targetPath_r; // RULE_08
        end
    end

    // System clock level: follows the active path in run, may only fall with it while draining, and is held low while armed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            systemClock_r <= 1'b0;
        end else if (swState_r == scs_pkg::SW_ARM) begin
            systemClock_r <= 1'b0; // RULE_08
        end else if (swState_r == scs_pkg::SW_DRAIN) begin
            // A high phase under way may finish, but no new pulse starts while draining.
            systemClock_r <= systemClock_r & activeLevel; // RULE_08
        end else begin
            systemClock_r <= activeLevel; // RULE_01
        end
    end

    // Flag showing that the reserved select code is being applied.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reservedSel_r <= 1'b0;
        end else begin
            reservedSel_r <= (clockSourceSelect == scs_pkg::SEL_RESERVED); // RULE_08
        end
    end

    assign systemClock    = systemClock_r;
    assign activePath     = activePath_r;
    assign switchBusy     = (swState_r != scs_pkg::SW_RUN);
    assign reservedSelect = reservedSel_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Each path is checked while no switch is under way.
    direct_drive_a: assert property ( // RULE_01
        swState_r == scs_pkg::SW_RUN && activePath_r == scs_pkg::PATH_DIRECT
        |=> systemClock_r == $past(directClockInput))
        else $error("system clock does not follow the direct input");
    prescale_path_a: assert property ( // RULE_02
        swState_r == scs_pkg::SW_RUN && activePath_r == scs_pkg::PATH_PRESCALE
        |=> systemClock_r == $past(prescaleClk))
        else $error("system clock does not follow the prescaler");
    pll_path_a: assert property ( // RULE_06
        swState_r == scs_pkg::SW_RUN && activePath_r == scs_pkg::PATH_PLL
        |=> systemClock_r == $past(pllClock))
        else $error("system clock does not follow the PLL");
    wakeup_path_a: assert property ( // RULE_07
        swState_r == scs_pkg::SW_RUN && activePath_r == scs_pkg::PATH_WAKEUP
        |=> systemClock_r == $past(wakeupClock))
        else $error("system clock does not follow the wakeup clock");
    hold_low_a: assert property ( // RULE_08
        swState_r == scs_pkg::SW_ARM |-> !systemClock_r)
        else $error("system clock high during switch hold");
    drain_no_rise_a: assert property ( // RULE_08
        swState_r == scs_pkg::SW_DRAIN && !systemClock_r |=> !systemClock_r)
        else $error("new system clock pulse started while draining");
    reserved_ignored_a: assert property ( // RULE_08
        swState_r == scs_pkg::SW_RUN && clockSourceSelect == scs_pkg::SEL_RESERVED
        |=> swState_r == scs_pkg::SW_RUN && $stable(activePath_r))
        else $error("reserved select code changed the path");
    select_map_a: assert property ( // RULE_02
        swState_r == scs_pkg::SW_RUN && clockSourceSelect == scs_pkg::SEL_PRESCALE
        && vcoBypass && activePath_r != scs_pkg::PATH_PRESCALE
        |=> swState_r == scs_pkg::SW_DRAIN && targetPath_r == scs_pkg::PATH_PRESCALE)
        else $error("prescale select did not start a switch to the prescaler");
    path_change_a: assert property ( // RULE_08
        $changed(activePath_r) |-> $past(swState_r) == scs_pkg::SW_ARM
        && !$past(systemClock_r) && !systemClock_r)
        else $error("path changed outside the hold-low phase");

    cover_to_direct: cover property (
        $changed(activePath_r) && activePath_r == scs_pkg::PATH_DIRECT);
    cover_to_pll: cover property (
        $changed(activePath_r) && activePath_r == scs_pkg::PATH_PLL);
    cover_reserved: cover property (reservedSel_r && swState_r == scs_pkg::SW_RUN);
    cover_to_wakeup: cover property (
        $changed(activePath_r) && activePath_r == scs_pkg::PATH_WAKEUP);

endmodule // scs_clock_select
`default_nettype wire

//--- tb/scs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// Free-running clock source, seen as a level that toggles every HALF clk cycles.
module scs_src_model #(
    parameter int HALF = 1
) (
    input  wire logic clk,
    output logic      level
);
    int cnt; // Cycles spent in the current half period.
    // Sources are already running when the device leaves reset. The level toggles
    // just after the edge, so the sampling edge never races the change.
    initial begin
        cnt = 0;
        level = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (cnt >= HALF - 1) begin
                cnt = 0;
                level = ~level;
            end else begin
                cnt = cnt + 1;
            end
        end
    end
endmodule // scs_src_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the system clock source selector.
module tb_top;
    logic       clk, rst_n, useInternalOsc, vcoBypass; // Bench-driven controls.
    logic [1:0] clockSourceSelect;                     // Source select code.
    logic [9:0] prescalerDividerField;                 // Factor minus one.
    logic       dIn, xIn, iIn, pIn, wIn;               // Source levels.
    logic       systemClock, switchBusy, reservedSelect;
    logic [1:0] activePath;
    logic [4:0] hist [0:1];                            // Sampled source history.
    int         numErrors, comparisons;                // Report counters.
    // Source models: direct, crystal, internal, PLL and wakeup.
    scs_src_model #(.HALF(3)) mD (.clk(clk), .level(dIn));
    scs_src_model #(.HALF(1)) mX (.clk(clk), .level(xIn));
    scs_src_model #(.HALF(2)) mI (.clk(clk), .level(iIn));
    scs_src_model #(.HALF(1)) mP (.clk(clk), .level(pIn));
    scs_src_model #(.HALF(5)) mW (.clk(clk), .level(wIn));
    scs_clock_select dut (.clk(clk), .rst_n(rst_n), .directClockInput(dIn),
        .crystalInput(xIn), .internalClockSource(iIn), .useInternalOsc(useInternalOsc),
        .pllClock(pIn), .wakeupClock(wIn), .clockSourceSelect(clockSourceSelect),
        .vcoBypass(vcoBypass), .prescalerDividerField(prescalerDividerField),
        .systemClock(systemClock), .activePath(activePath), .switchBusy(switchBusy),
        .reservedSelect(reservedSelect));
    // History of source levels as the device samples them, bit index is the source.
    always @(posedge clk) begin
        hist[0] <= {wIn, pIn, iIn, xIn, dIn};
        hist[1] <= hist[0];
    end
    // Clock of 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic endOfTest;
        $display("Comparisons %0d, mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one output bit.
    task automatic chkBit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Compares the reported path.
    task automatic chkPath(input logic [1:0] exp);
        comparisons++;
        if (activePath !== exp) begin
            numErrors++;
            $display("[FAIL] activePath expected %b seen %b", exp, activePath);
        end
    endtask
    // Compares a measured cycle count.
    task automatic chkCnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            numErrors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Moves to a settled point after the next edge.
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    // Moves to the drive point just after the next edge.
    task automatic drv;
        @(posedge clk);
        #1;
    endtask
    // Counts cycles up to the next rising system clock, and its high cycles.
    task automatic cyc(output int per, output int high);
        logic prev;
        per = 0;
        high = 0;
        forever begin
            prev = systemClock;
            if (prev === 1'b1) high++;
            tick();
            per++;
            if (prev === 1'b0 && systemClock === 1'b1) break;
            if (per > 5000) begin
                numErrors++;
                $display("[FAIL] system clock edge wait timed out");
                endOfTest();
            end
        end
    endtask
    // Checks that the system clock copies source idx lag cycles after it changes.
    // The output register is the first cycle of lag, so hist[0] stands for lag 1.
    task automatic follow(input int idx, input int lag, input int n);
        repeat (n) begin
            tick();
            chkBit("systemClock", hist[lag - 1][idx], systemClock);
        end
    endtask
    // Starts a switch and watches it: no new rising pulse while busy.
    task automatic switchTo(input logic [1:0] sel, input logic byp, input logic [1:0] path);
        int n, rises;
        logic prev;
        drv();
        clockSourceSelect = sel;
        vcoBypass = byp;
        tick();
        chkBit("switchBusy", 1'b1, switchBusy);
        n = 0;
        rises = 0;
        while (switchBusy === 1'b1 && n < 3000) begin
            prev = systemClock;
            tick();
            n++;
            if (prev === 1'b0 && systemClock === 1'b1 && switchBusy === 1'b1) rises++;
        end
        chkBit("switch finished", 1'b0, switchBusy);
        // A switch that never ends has been counted and closes the run.
        if (switchBusy !== 1'b0) begin
            endOfTest();
        end
        chkCnt("pulses while switching", 0, rises);
        chkPath(path);
        repeat (3) tick();
    endtask
    // Reset values, then the wakeup clock drives the output.
    task automatic testReset;
        rst_n = 1'b0;
        repeat (5) tick();
        chkBit("systemClock", 1'b0, systemClock);
        chkBit("switchBusy", 1'b0, switchBusy);
        chkBit("reservedSelect", 1'b0, reservedSelect);
        chkPath(2'h0);
        drv();
        rst_n = 1'b1;
        repeat (3) tick();
        follow(4, 1, 24);
        $display("Test reset and wakeup done");
    endtask
    // Code 01 keeps the path and is flagged one cycle later.
    task automatic testReserved;
        drv();
        clockSourceSelect = 2'h1;
        tick();
        chkBit("reservedSelect", 1'b1, reservedSelect);
        chkBit("switchBusy", 1'b0, switchBusy);
        chkPath(2'h3);
        follow(0, 1, 8);
        drv();
        clockSourceSelect = 2'h3;
        tick();
        chkBit("reservedSelect", 1'b0, reservedSelect);
        $display("Test reserved code done");
    endtask
    // Prescaler factors of three and of 1024 from the crystal.
    task automatic testDivide;
        int per, high;
        drv();
        prescalerDividerField = 10'h002;
        repeat (3) cyc(per, high);
        chkCnt("period K=3", 6, per);
        chkCnt("high K=3", 4, high);
        drv();
        prescalerDividerField = 10'h3ff;
        repeat (3) cyc(per, high);
        chkCnt("period K=1024", 2048, per);
        chkCnt("high K=1024", 1024, high);
        $display("Test prescaler factors done");
    endtask
    // Direct drive: the output follows the direct input.
    task automatic testDirect;
        switchTo(2'h3, 1'b0, 2'h3);
        follow(0, 1, 30);
        $display("Test direct drive done");
    endtask
    // Select 10 without bypass: the output follows the PLL.
    task automatic testPll;
        switchTo(2'h2, 1'b0, 2'h1);
        follow(3, 1, 20);
        $display("Test PLL done");
    endtask
    // Prescaler at factor one, first from the crystal, then from the internal source.
    task automatic testFactorOne;
        switchTo(2'h2, 1'b1, 2'h2);
        follow(1, 2, 20);
        drv();
        useInternalOsc = 1'b1;
        repeat (6) tick();
        follow(2, 2, 20);
        drv();
        useInternalOsc = 1'b0;
        $display("Test prescaler factor one done");
    endtask
    // Back to the wakeup clock while the slow prescaler is in its high phase.
    task automatic testWakeupReturn;
        switchTo(2'h0, 1'b1, 2'h0);
        follow(4, 1, 24);
        $display("Test return to wakeup done");
    endtask
    // Main sequence.
    initial begin
        numErrors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        useInternalOsc = 1'b0;
        vcoBypass = 1'b0;
        clockSourceSelect = 2'h0;
        prescalerDividerField = 10'h000;
        testReset();
        testDirect();
        testReserved();
        testPll();
        testFactorOne();
        testDivide();
        testWakeupReturn();
        endOfTest();
    end
endmodule // tb_top
`default_nettype wire
